/* File: design/ufl_pkg.sv */
// Contract
// - scratch at 0x07 when line bit7=0, modem bit2=0
// - scratch resets FF, only power-on reset loads it
// - thresholds at 0x07 when features4=1, modem2=1, stop char not selected
// - rx ready when fill >= 4 x upper nibble
// - upper nibble zero uses fifo_control[7:6] level
// - tx ready when free >= 4 x lower nibble
// - lower nibble zero uses fifo_control[5:4] level
// - stop char at 0x07 when line=BF, unlock!=5A
// - 0x08 reads tx free space when special_function bit2=0, reset 0x40
// - 0x09 reads rx fill count when special_function bit2=0, reset zero
// - direction bit 1 output, 0 input, reset inputs
// - pin state reads pins, writes drive outputs
// - gpio registers shared by both channels
package ufl_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] OFS_SHARED  = 4'h7;
  localparam logic [3:0] OFS_TX_FREE = 4'h8;
  localparam logic [3:0] OFS_RX_FILL = 4'h9;
  localparam logic [3:0] OFS_GPIO_DIR = 4'hA;
  localparam logic [3:0] OFS_GPIO_VAL = 4'hB;
  // ==========================================================
  // reset values and keys
  localparam logic [7:0] RST_SCRATCH  = 8'hFF;
  localparam logic [7:0] RST_THRESH   = 8'h00;
  localparam logic [7:0] RST_STOP2    = 8'h00;
  localparam logic [7:0] RST_GPIO_DIR = 8'h00;
  localparam logic [7:0] RST_GPIO_VAL = 8'hFF;
  localparam logic [6:0] RST_TX_FREE  = 7'h40;
  localparam logic [6:0] RST_RX_FILL  = 7'h00;
  localparam logic [7:0] LINE_KEY     = 8'hBF;
  localparam logic [7:0] UNLOCK_KEY   = 8'h5A;
  localparam int         LINE_DLAB    = 7;
  localparam int         MODEM_SEL    = 2;
  localparam int         FEAT_ENH     = 4;
  localparam int         SFR_SEL      = 2;
  // legacy trigger levels chosen by the two-bit selects
  localparam logic [6:0] RX_LVL0 = 7'h08;
  localparam logic [6:0] RX_LVL1 = 7'h10;
  localparam logic [6:0] RX_LVL2 = 7'h38;
  localparam logic [6:0] RX_LVL3 = 7'h3C;
  localparam logic [6:0] TX_LVL0 = 7'h08;
  localparam logic [6:0] TX_LVL1 = 7'h10;
  localparam logic [6:0] TX_LVL2 = 7'h20;
  localparam logic [6:0] TX_LVL3 = 7'h38;

  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] enhanced_features;
    logic [7:0] fifo_control;
    logic [7:0] special_function;
    logic [7:0] special_function_unlock;
  } ufl_ctrl_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       chan;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ufl_req_t;
endpackage

/* File: design/ufl_trigger.sv */
`timescale 1ns/10ps
// per-channel trigger comparison; outputs registered
module ufl_trigger (
  input  wire logic             mclk_in,      // clock
  input  wire logic             sys_rst_in,   // sync reset
  input  wire logic [7:0]       thresh_in,    // trigger thresholds
  input  wire logic [7:0]       fifo_ctl_in,  // fifo_control
  input  wire logic [6:0]       rx_fill_in,   // rx fill count
  input  wire logic [6:0]       tx_free_in,   // tx free space
  output logic                  rx_ready_out, // receive data ready
  output logic                  tx_ready_out  // transmit ready
);
  logic [6:0] rx_lvl, tx_lvl;
  logic       rx_next, tx_next;

  always_comb begin
    case (fifo_ctl_in[7:6])
      2'h0: rx_lvl = ufl_pkg::RX_LVL0;
      2'h1: rx_lvl = ufl_pkg::RX_LVL1;
      2'h2: rx_lvl = ufl_pkg::RX_LVL2;
      default: rx_lvl = ufl_pkg::RX_LVL3;
    endcase
    if (thresh_in[7:4] != 4'h0) begin
      rx_lvl = {1'b0, thresh_in[7:4], 2'b00};
    end
    case (fifo_ctl_in[5:4])
      2'h0: tx_lvl = ufl_pkg::TX_LVL0;
      2'h1: tx_lvl = ufl_pkg::TX_LVL1;
      2'h2: tx_lvl = ufl_pkg::TX_LVL2;
      default: tx_lvl = ufl_pkg::TX_LVL3;
    endcase
    if (thresh_in[3:0] != 4'h0) begin
      tx_lvl = {1'b0, thresh_in[3:0], 2'b00};
    end
    rx_next = rx_fill_in >= rx_lvl;
    tx_next = tx_free_in >= tx_lvl;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rx_ready_out <= 1'b0;
      tx_ready_out <= 1'b0;
    end else begin
      rx_ready_out <= rx_next;
      tx_ready_out <= tx_next;
    end
  end
endmodule // ufl_trigger

/* File: design/ufl_regs.sv */
`timescale 1ns/10ps
module ufl_regs (
  input  wire logic              mclk_in,       // clock
  input  wire logic              sys_rst_in,    // power-on reset
  input  wire logic              soft_rst_in,   // software reset
  input  wire ufl_pkg::ufl_req_t req_in,        // decoded slave-port access
  input  wire ufl_pkg::ufl_ctrl_t ctrl_a_in,    // channel A control regs
  input  wire ufl_pkg::ufl_ctrl_t ctrl_b_in,    // channel B control regs
  input  wire logic [13:0]       tx_free_in,    // tx free space, B:A
  input  wire logic [13:0]       rx_fill_in,    // rx fill count, B:A
  input  wire logic [7:0]        gpio_pin_in,   // gpio pad levels
  output logic [7:0]             rdata_out,     // read data
  output logic                   rhit_out,      // read hit this block
  output logic [7:0]             gpio_out,      // gpio output value
  output logic [7:0]             gpio_oe_out,   // gpio output enable
  output logic [1:0]             rx_ready_out,  // rx trigger, per channel
  output logic [1:0]             tx_ready_out   // tx trigger, per channel
);
  // ==========================================================
  // per-channel and shared storage
  typedef enum logic [1:0] {
    UFL_SEL_NONE    = 2'b00,
    UFL_SEL_SCRATCH = 2'b01,
    UFL_SEL_THRESH  = 2'b10,
    UFL_SEL_STOP2   = 2'b11
  } ufl_sel_t;

  logic [7:0] scratch_reg [2], scratch_next [2];
  logic [7:0] thresh_reg [2], thresh_next [2];
  logic [7:0] stop2_reg [2], stop2_next [2];
  logic [7:0] dir_reg, dir_next, val_reg, val_next;
  logic [7:0] pin_s1_reg, pin_s2_reg;
  logic [7:0] rdata_next;
  logic       rhit_next;
  logic [6:0] txf_reg [2], rxf_reg [2];

  function automatic ufl_sel_t sel_shared(input ufl_pkg::ufl_ctrl_t c);
    if (c.line_control == ufl_pkg::LINE_KEY &&
        c.special_function_unlock != ufl_pkg::UNLOCK_KEY) begin
      return UFL_SEL_STOP2;
    end else if (c.enhanced_features[ufl_pkg::FEAT_ENH] &&
                 c.modem_control[ufl_pkg::MODEM_SEL]) begin
      return UFL_SEL_THRESH;
    end else if (!c.line_control[ufl_pkg::LINE_DLAB] &&
                 !c.modem_control[ufl_pkg::MODEM_SEL]) begin
      return UFL_SEL_SCRATCH;
    end
    return UFL_SEL_NONE;
  endfunction

  ufl_pkg::ufl_ctrl_t cur;
  ufl_sel_t           sel;
  int                 ch;

  always_comb begin
    cur = req_in.chan ? ctrl_b_in : ctrl_a_in;
    sel = sel_shared(cur);
    ch  = req_in.chan ? 1 : 0;
    for (int i = 0; i < 2; i++) begin
      scratch_next[i] = scratch_reg[i];
      thresh_next[i]  = soft_rst_in ? ufl_pkg::RST_THRESH : thresh_reg[i];
      stop2_next[i]   = stop2_reg[i];
    end
    dir_next   = soft_rst_in ? ufl_pkg::RST_GPIO_DIR : dir_reg;
    val_next   = soft_rst_in ? ufl_pkg::RST_GPIO_VAL : val_reg;
    rdata_next = 8'h00;
    rhit_next  = 1'b0;
    if (req_in.wr && !soft_rst_in) begin
      case (req_in.addr)
        ufl_pkg::OFS_SHARED: begin
          case (sel)
            UFL_SEL_SCRATCH: scratch_next[ch] = req_in.wdata;
            UFL_SEL_THRESH:  thresh_next[ch]  = req_in.wdata;
            UFL_SEL_STOP2:   stop2_next[ch]   = req_in.wdata;
            default: ;
          endcase
        end
        ufl_pkg::OFS_GPIO_DIR: dir_next = req_in.wdata;
        ufl_pkg::OFS_GPIO_VAL: val_next = req_in.wdata;
        default: ; // level counts are read-only
      endcase
    end
    if (req_in.rd) begin
      case (req_in.addr)
        ufl_pkg::OFS_SHARED: begin
          rhit_next = sel != UFL_SEL_NONE;
          case (sel)
            UFL_SEL_SCRATCH: rdata_next = scratch_reg[ch];
            UFL_SEL_THRESH:  rdata_next = thresh_reg[ch];
            UFL_SEL_STOP2:   rdata_next = stop2_reg[ch];
            default:         rdata_next = 8'h00;
          endcase
        end
        ufl_pkg::OFS_TX_FREE: begin
          rhit_next  = !cur.special_function[ufl_pkg::SFR_SEL];
          rdata_next = rhit_next ? {1'b0, txf_reg[ch]} : 8'h00;
        end
        ufl_pkg::OFS_RX_FILL: begin
          rhit_next  = !cur.special_function[ufl_pkg::SFR_SEL];
          rdata_next = rhit_next ? {1'b0, rxf_reg[ch]} : 8'h00;
        end
        ufl_pkg::OFS_GPIO_DIR: begin
          rhit_next  = 1'b1;
          rdata_next = dir_reg;
        end
        ufl_pkg::OFS_GPIO_VAL: begin
          rhit_next  = 1'b1;
          rdata_next = pin_s2_reg;
        end
        default: ;
      endcase
    end
  end

  // scratch and stop char survive software reset
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < 2; i++) begin
        scratch_reg[i] <= ufl_pkg::RST_SCRATCH;
        thresh_reg[i]  <= ufl_pkg::RST_THRESH;
        stop2_reg[i]   <= ufl_pkg::RST_STOP2;
      end
      dir_reg      <= ufl_pkg::RST_GPIO_DIR;
      val_reg      <= ufl_pkg::RST_GPIO_VAL;
      rdata_out    <= 8'h00;
      rhit_out     <= 1'b0;
    end else begin
      scratch_reg  <= scratch_next;
      thresh_reg   <= thresh_next;
      stop2_reg    <= stop2_next;
      dir_reg      <= dir_next;
      val_reg      <= val_next;
      rdata_out    <= rdata_next;
      rhit_out     <= rhit_next;
    end
  end

  // ==========================================================
  // level snapshot and gpio pads
  // pads are asynchronous: two flops before any reader
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pin_s1_reg  <= 8'h00;
      pin_s2_reg  <= 8'h00;
      gpio_out    <= ufl_pkg::RST_GPIO_VAL;
      gpio_oe_out <= ufl_pkg::RST_GPIO_DIR;
      txf_reg[0]  <= ufl_pkg::RST_TX_FREE;
      txf_reg[1]  <= ufl_pkg::RST_TX_FREE;
      rxf_reg[0]  <= ufl_pkg::RST_RX_FILL;
      rxf_reg[1]  <= ufl_pkg::RST_RX_FILL;
    end else begin
      pin_s1_reg  <= gpio_pin_in;
      pin_s2_reg  <= pin_s1_reg;
      gpio_out    <= val_next;
      gpio_oe_out <= dir_next;
      txf_reg[0]  <= soft_rst_in ? ufl_pkg::RST_TX_FREE : tx_free_in[6:0];
      txf_reg[1]  <= soft_rst_in ? ufl_pkg::RST_TX_FREE : tx_free_in[13:7];
      rxf_reg[0]  <= soft_rst_in ? ufl_pkg::RST_RX_FILL : rx_fill_in[6:0];
      rxf_reg[1]  <= soft_rst_in ? ufl_pkg::RST_RX_FILL : rx_fill_in[13:7];
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_trig
    ufl_trigger u_trig (
      .mclk_in      (mclk_in),
      .sys_rst_in   (sys_rst_in),
      .thresh_in    (thresh_reg[g]),
      .fifo_ctl_in  (g == 0 ? ctrl_a_in.fifo_control : ctrl_b_in.fifo_control),
      .rx_fill_in   (rxf_reg[g]),
      .tx_free_in   (txf_reg[g]),
      .rx_ready_out (rx_ready_out[g]),
      .tx_ready_out (tx_ready_out[g])
    );
  end
endmodule // ufl_regs

/* File: test/ufl_regs_sva.sv */
`timescale 1ns/10ps
// ========================================
// port checks for the register slice
module ufl_regs_chk (
  input wire logic               mclk_in,      // clock
  input wire logic               sys_rst_in,   // power-on reset
  input wire logic               soft_rst_in,  // software reset
  input wire ufl_pkg::ufl_req_t  req_in,       // access
  input wire ufl_pkg::ufl_ctrl_t ctrl_a_in,    // channel A control
  input wire ufl_pkg::ufl_ctrl_t ctrl_b_in,    // channel B control
  input wire logic [13:0]        rx_fill_in,   // rx fill counts
  input wire logic [7:0]         rdata_out,    // read data
  input wire logic               rhit_out,     // read hit
  input wire logic [7:0]         gpio_out,     // pin drive value
  input wire logic [7:0]         gpio_oe_out,  // pin drive enable
  input wire logic [1:0]         rx_ready_out  // rx trigger
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic sfr_sel = req_in.chan ? ctrl_b_in.special_function[2]
                                   : ctrl_a_in.special_function[2];
  idle_quiet_a:
    assert property (!$past(req_in.rd) |-> !rhit_out && rdata_out == 8'h00)
      else $error("read data outside answer");
  lvl_blocked_a:
    assert property (req_in.rd && req_in.addr inside {4'h8, 4'h9} && sfr_sel
                     |=> !rhit_out && rdata_out == 8'h00)
      else $error("level read not blocked");
  lvl_hit_a:
    assert property (req_in.rd && !soft_rst_in && req_in.addr == 4'h9 && !sfr_sel
                     |=> rhit_out)
      else $error("rx level read missed");
  dir_write_a:
    assert property (req_in.wr && !soft_rst_in && req_in.addr == 4'hA
                     |=> gpio_oe_out == $past(req_in.wdata))
      else $error("direction write lost");
  val_write_a:
    assert property (req_in.wr && !soft_rst_in && req_in.addr == 4'hB
                     |=> gpio_out == $past(req_in.wdata))
      else $error("pin value write lost");
  gpio_hold_a:
    assert property (!req_in.wr && !soft_rst_in
                     |=> $stable(gpio_out) && $stable(gpio_oe_out))
      else $error("gpio moved without write");
  ro_write_a:
    assert property (req_in.wr && !soft_rst_in && req_in.addr inside {4'h8, 4'h9}
                     |=> $stable(gpio_oe_out) && $stable(gpio_out))
      else $error("level write had effect");
  rst_value_a:
    assert property ($past(sys_rst_in)
                     |-> gpio_oe_out == 8'h00 && gpio_out == 8'hFF && !rhit_out)
      else $error("bad reset values");
  rx_min_a:
    assert property (rx_ready_out[0] |-> $past(rx_fill_in[6:0], 2) >= 7'h04)
      else $error("rx ready below least level");
endmodule // ufl_regs_chk
bind ufl_regs ufl_regs_chk chk (.mclk_in, .sys_rst_in, .soft_rst_in, .req_in, .ctrl_a_in,
  .ctrl_b_in, .rx_fill_in, .rdata_out, .rhit_out, .gpio_out, .gpio_oe_out, .rx_ready_out);

/* File: test/ufl_host.sv */
`timescale 1ns/10ps
// ========================================
// host side of the slave port
module ufl_host (
  input  wire logic        mclk_in,  // clock
  input  wire logic [7:0]  rdata_in, // read data
  input  wire logic        rhit_in,  // read hit
  output ufl_pkg::ufl_req_t req_out  // access pulse
);
  initial req_out = '0;
  // launched on the falling edge; the block answers on the taking edge, sampled half a cycle later
  task automatic acc(input logic w, input logic c, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge mclk_in);
    req_out = '{rd: !w, wr: w, chan: c, addr: a, wdata: d};
    @(negedge mclk_in);
    req_out = '0;
    q = rdata_in;
  endtask
endmodule // ufl_host

/* File: test/uart_fifo_level_gpio_regs_test.sv */
`timescale 1ns/10ps
module uart_fifo_level_gpio_regs_test;
  logic mclk_in = 0, sys_rst_in = 1, soft_rst_in = 0;
  ufl_pkg::ufl_req_t  req_in;
  ufl_pkg::ufl_ctrl_t ctrl_a_in = '0, ctrl_b_in = '0;
  logic [13:0] tx_free_in = 14'h2040, rx_fill_in = 14'h0000;
  logic [7:0]  ext_pins = 8'hC3, rdata_out, gpio_out, gpio_oe_out;
  logic [1:0]  rx_ready_out, tx_ready_out;
  logic        rhit_out;
  int          err_total = 0, cmp_count = 0;
  // pads follow the block where it drives, the outside world elsewhere
  wire logic [7:0] gpio_pin_in = (gpio_oe_out & gpio_out) | (~gpio_oe_out & ext_pins);
  always #5 mclk_in = ~mclk_in;
  ufl_host host (.mclk_in, .rdata_in(rdata_out), .rhit_in(rhit_out), .req_out(req_in));
  ufl_regs dut (.mclk_in, .sys_rst_in, .soft_rst_in, .req_in, .ctrl_a_in, .ctrl_b_in,
    .tx_free_in, .rx_fill_in, .gpio_pin_in, .rdata_out, .rhit_out, .gpio_out, .gpio_oe_out,
    .rx_ready_out, .tx_ready_out);
  // ========================================
  // shared helpers
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic c, input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.acc(1'b1, c, a, d, q);
  endtask
  task automatic rd(input logic c, input logic [3:0] a, input logic [7:0] e, input string n);
    logic [7:0] q;
    host.acc(1'b0, c, a, 8'h00, q);
    chk(n, e, q);
  endtask
  task automatic trg(input logic [6:0] rf, input logic [6:0] tf, input logic [7:0] e);
    rx_fill_in[6:0] = rf;
    tx_free_in[6:0] = tf;
    repeat (4) @(negedge mclk_in);
    chk("ready rx,tx", e, {6'h00, rx_ready_out[0], tx_ready_out[0]});
  endtask
  // ========================================
  // scenarios
  task automatic t_reset;
    rd(1'b0, 4'h7, 8'hFF, "scratch");
    rd(1'b0, 4'h8, 8'h40, "tx free");
    rd(1'b1, 4'h9, 8'h00, "rx fill");
    rd(1'b0, 4'hA, 8'h00, "direction");
    rd(1'b0, 4'hB, 8'hC3, "pin state");
    chk("ready B rx,tx", 8'h01, {6'h00, rx_ready_out[1], tx_ready_out[1]});
    $display("test reset done");
  endtask
  task automatic t_map;
    wr(1'b0, 4'h7, 8'h5C);
    rd(1'b0, 4'h7, 8'h5C, "scratch");
    ctrl_a_in = 48'h00_04_10_00_00_00;
    rd(1'b0, 4'h7, 8'h00, "thresholds");
    wr(1'b0, 4'h7, 8'h34);
    ctrl_a_in = 48'hBF_04_10_00_00_00;
    rd(1'b0, 4'h7, 8'h00, "stop char");
    wr(1'b0, 4'h7, 8'h3E);
    rd(1'b0, 4'h7, 8'h3E, "stop char");
    ctrl_a_in = 48'hBF_00_00_00_00_5A;
    rd(1'b0, 4'h7, 8'h00, "no select");
    ctrl_a_in = 48'h00_04_10_00_00_00;
    rd(1'b0, 4'h7, 8'h34, "thresholds");
    ctrl_a_in = 48'h00_00_10_00_04_00;
    rd(1'b0, 4'h7, 8'h5C, "scratch");
    rd(1'b0, 4'h8, 8'h00, "tx free hidden");
    ctrl_a_in = 48'h00_00_10_00_00_00;
    wr(1'b0, 4'h8, 8'h00);
    rd(1'b0, 4'h8, 8'h40, "tx free");
    $display("test map done");
  endtask
  task automatic t_trig;
    trg(7'd11, 7'd15, 8'h00);
    trg(7'd12, 7'd16, 8'h03);
    ctrl_a_in = 48'h00_04_10_40_00_00;
    wr(1'b0, 4'h7, 8'h00);
    ctrl_a_in = 48'h00_00_10_40_00_00;
    trg(7'd15, 7'd7, 8'h00);
    trg(7'd16, 7'd8, 8'h03);
    rx_fill_in[6:0] = 7'h00;
    tx_free_in[6:0] = 7'h40;
    $display("test trigger done");
  endtask
  task automatic t_gpio;
    wr(1'b0, 4'hA, 8'hF0);
    wr(1'b0, 4'hB, 8'h5A);
    chk("pin enable", 8'hF0, gpio_oe_out);
    chk("pin drive", 8'h5A, gpio_out);
    rd(1'b1, 4'hA, 8'hF0, "shared dir");
    rd(1'b1, 4'hB, 8'h53, "pin state");
    soft_rst_in = 1;
    @(negedge mclk_in);
    soft_rst_in = 0;
    rd(1'b0, 4'hA, 8'h00, "direction");
    rd(1'b0, 4'h7, 8'h5C, "scratch kept");
    ctrl_a_in = 48'hBF_00_10_40_00_00;
    rd(1'b0, 4'h7, 8'h3E, "stop kept");
    $display("test gpio done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge mclk_in);
    sys_rst_in = 0;
    t_reset();
    t_map();
    t_trig();
    t_gpio();
    finish_test();
  end
  // whole run is some seventy cycles
  initial begin
    #20000;
    err_total++;
    finish_test();
  end
endmodule // uart_fifo_level_gpio_regs_test
